/* core/lbbd_pkg.sv */
// lbbd_pkg: constants for the local bus bank base/decode block
// assumes: used by package-qualified names only, nothing imported
package lbbd_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  BASE_OFS     = 8'h00;
  localparam logic [7:0]  MASK_OFS     = 8'h20;
  localparam logic [7:0]  CTRL_OFS     = 8'h40;
  localparam logic [7:0]  STAT_OFS     = 8'h44;
  // ----------------------------------------------------------------
  // base register fields (bit 0 of the printed layout is the msb)
  // ----------------------------------------------------------------
  localparam int          BA_LSB       = 15;
  localparam int          PW_LSB       = 11;
  localparam int          PM_LSB       = 9;
  localparam int          WP_BIT       = 8;
  localparam int          MC_LSB       = 5;
  localparam int          XM_LSB       = 2;
  localparam int          V_BIT        = 0;
  localparam logic [31:0] BASE_WMASK   = 32'hFFFF_9FED;
  localparam logic [31:0] BASE0_RST    = 32'h0000_0001;
  localparam logic [31:0] BASEN_RST    = 32'h0000_0000;
  localparam logic [16:0] MASK_RST     = 17'h1_FFFF;
  // ctrl bits: write-protect report, atomic report, bus error pulse
  localparam int          CT_WP_EN     = 0;
  localparam int          CT_AT_EN     = 1;
  localparam int          CT_IRQ_EN    = 2;
  localparam logic [2:0]  CTRL_RST     = 3'h0;
  localparam int          ST_WP_ERR    = 0;
  localparam int          ST_AT_ERR    = 1;
  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  PW_UNDEF     = 2'h0;
  localparam logic [1:0]  PW_8         = 2'h1;
  localparam logic [1:0]  PW_16        = 2'h2;
  localparam logic [1:0]  PW_32        = 2'h3;
  localparam logic [1:0]  PM_GEN_ONLY  = 2'h0;
  localparam logic [1:0]  PM_CHECK     = 2'h1;
  localparam logic [1:0]  PM_RMW       = 2'h2;
  localparam logic [1:0]  XM_NONE      = 2'h0;
  localparam logic [1:0]  XM_RAW       = 2'h1;
  localparam logic [1:0]  XM_WAR       = 2'h2;
  typedef enum logic [2:0] {
    MC_GENERAL = 3'b000,
    MC_SDRAM   = 3'b011,
    MC_USER_A  = 3'b100,
    MC_USER_B  = 3'b101,
    MC_USER_C  = 3'b110
  } lbbd_machine_t;
  typedef enum logic [0:0] {
    TS_IDLE = 1'b0,
    TS_OWN  = 1'b1
  } lbbd_tstate_t;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          RESV_LIMIT_CYC = 256;
  localparam int          STRAP_SETTLE   = 3;
endpackage

/* core/lbbd_bank_decode.sv */
// lbbd_bank_decode: eight bank base registers, compare masks and the
// address decode that picks a bank, its machine and its chip select
// assumes: avalon-mm master on core_clk_i; transaction source on the
// same clock; boot port width straps arrive from pins
`timescale 1ns/100ps
`default_nettype none
module lbbd_bank_decode #(
  parameter int ID_W = 4
) (
  // clock, reset, enable
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             clk_en_i,
  // avalon-mm slave
  input  wire logic [7:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  // boot strap pins
  input  wire logic [1:0]       boot_port_width_i,
  // transaction request
  input  wire logic             tr_valid_i,
  input  wire logic [31:0]      tr_addr_i,
  input  wire logic             tr_write_i,
  input  wire logic [ID_W-1:0]  tr_master_i,
  input  wire logic             tr_end_i,
  // transaction answer
  output logic                  tr_accept_o,
  output logic                  tr_term_o,
  output logic                  tr_nomatch_o,
  output logic                  bus_err_o,
  output logic      [7:0]       chip_select_out_b_o,
  output logic      [2:0]       machine_choice_o,
  output logic      [1:0]       port_width_o,
  output logic      [1:0]       parity_mode_o
);
  // ----------------------------------------------------------------
  // field helpers
  // ----------------------------------------------------------------
  function automatic logic bank_hit(input logic [31:0] b, input logic [16:0] m, input logic [31:0] a);
    bank_hit = b[lbbd_pkg::V_BIT] && (((b[31:lbbd_pkg::BA_LSB] ^ a[31:lbbd_pkg::BA_LSB]) & m) == 17'h0_0000);
  endfunction
  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] be);
    be_merge = o;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        be_merge[k*8 +: 8] = d[k*8 +: 8];
      end
    end
  endfunction
  // ----------------------------------------------------------------
  // register bank and bus slave
  // ----------------------------------------------------------------
  logic [31:0] base_r   [8];
  logic [31:0] base_nxt [8];
  logic [16:0] mask_r   [8];
  logic [16:0] mask_nxt [8];
  logic [2:0]  ctrl_r, ctrl_nxt;
  logic [1:0]  stat_r, stat_nxt;
  logic        wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  strap1_r, strap2_r, strap3_r;
  logic [1:0]  settle_r, settle_nxt;
  logic        strap_done_r, strap_done_nxt;
  logic        wp_set, at_set;
  lbbd_pkg::lbbd_tstate_t ts_r, ts_nxt;
  logic [2:0]  own_bank_r, own_bank_nxt;

  always_comb begin
    logic       do_wr;
    logic [3:0] idx;
    do_wr      = avs_write_i && !wait_r;
    idx        = {1'b0, avs_address_i[4:2]};
    base_nxt   = base_r;
    mask_nxt   = mask_r;
    ctrl_nxt   = ctrl_r;
    stat_nxt   = stat_r;
    rdata_nxt  = rdata_r;
    settle_nxt = settle_r;
    strap_done_nxt = strap_done_r;
    // one cycle of wait per request: the answer is on the second edge
    wait_nxt   = !((avs_read_i || avs_write_i) && wait_r);
    // straps are taken once the synchroniser has settled and agrees
    if (!strap_done_r) begin
      if (settle_r != 2'(lbbd_pkg::STRAP_SETTLE)) begin
        settle_nxt = settle_r + 2'h1;
      end else if (strap2_r == strap3_r) begin
        base_nxt[0][lbbd_pkg::PW_LSB +: 2] = strap3_r;
        strap_done_nxt = 1'b1;
      end
    end
    if (do_wr) begin
      unique case (avs_address_i[7:5])
        3'h0: base_nxt[idx[2:0]] = be_merge(base_r[idx[2:0]], avs_writedata_i, avs_byteenable_i)
                                   & lbbd_pkg::BASE_WMASK;
        3'h1: mask_nxt[idx[2:0]] = 17'(be_merge({15'h0000, mask_r[idx[2:0]]}, avs_writedata_i,
                                   avs_byteenable_i));
        3'h2: begin
          if (avs_address_i == lbbd_pkg::CTRL_OFS && avs_byteenable_i[0]) begin
            ctrl_nxt = avs_writedata_i[2:0];
          end else if (avs_address_i == lbbd_pkg::STAT_OFS && avs_byteenable_i[0]) begin
            stat_nxt = stat_r & ~avs_writedata_i[1:0];
          end
        end
        default: ;
      endcase
    end
    // a hardware event wins over a same-cycle clear
    if (wp_set) begin
      stat_nxt[lbbd_pkg::ST_WP_ERR] = 1'b1;
    end
    if (at_set) begin
      stat_nxt[lbbd_pkg::ST_AT_ERR] = 1'b1;
    end
    if (avs_read_i && wait_r) begin
      unique case (avs_address_i[7:5])
        3'h0:    rdata_nxt = base_r[idx[2:0]];
        3'h1:    rdata_nxt = {15'h0000, mask_r[idx[2:0]]};
        3'h2: begin
          if (avs_address_i == lbbd_pkg::CTRL_OFS) begin
            rdata_nxt = {29'h0000_0000, ctrl_r};
          end else if (avs_address_i == lbbd_pkg::STAT_OFS) begin
            rdata_nxt = {20'h0_0000, ts_r, own_bank_r, 6'h00, stat_r};
          end else begin
            rdata_nxt = 32'h0000_0000;
          end
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 8; i++) begin
        base_r[i] <= (i == 0) ? lbbd_pkg::BASE0_RST : lbbd_pkg::BASEN_RST;
        mask_r[i] <= lbbd_pkg::MASK_RST;
      end
      ctrl_r       <= lbbd_pkg::CTRL_RST;
      stat_r       <= 2'h0;
      wait_r       <= 1'b1;
      rdata_r      <= 32'h0000_0000;
      strap1_r     <= 2'h0;
      strap2_r     <= 2'h0;
      strap3_r     <= 2'h0;
      settle_r     <= 2'h0;
      strap_done_r <= 1'b0;
    end else if (clk_en_i) begin
      base_r       <= base_nxt;
      mask_r       <= mask_nxt;
      ctrl_r       <= ctrl_nxt;
      stat_r       <= stat_nxt;
      wait_r       <= wait_nxt;
      rdata_r      <= rdata_nxt;
      strap1_r     <= boot_port_width_i;
      strap2_r     <= strap1_r;
      strap3_r     <= strap2_r;
      settle_r     <= settle_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // transaction decode, ownership and reservations
  // ----------------------------------------------------------------
  logic [7:0]      cs_b_r, cs_b_nxt;
  logic [2:0]      mc_r, mc_nxt;
  logic [1:0]      pw_r, pw_nxt, pm_r, pm_nxt;
  logic            acc_r, acc_nxt, term_r, term_nxt, nom_r, nom_nxt, berr_r, berr_nxt;
  logic [7:0]      resv_r, resv_nxt;
  logic [ID_W-1:0] resv_id_r  [8];
  logic [ID_W-1:0] resv_id_nxt[8];
  logic [8:0]      resv_cnt_r [8];
  logic [8:0]      resv_cnt_nxt[8];

  always_comb begin
    logic        hit;
    logic [2:0]  sel;
    logic [31:0] b;
    logic        same;
    hit          = 1'b0;
    sel          = 3'h0;
    b            = 32'h0000_0000;
    same         = 1'b0;
    ts_nxt       = ts_r;
    own_bank_nxt = own_bank_r;
    cs_b_nxt     = cs_b_r;
    mc_nxt       = mc_r;
    pw_nxt       = pw_r;
    pm_nxt       = pm_r;
    acc_nxt      = 1'b0;
    term_nxt     = 1'b0;
    nom_nxt      = 1'b0;
    berr_nxt     = 1'b0;
    wp_set       = 1'b0;
    at_set       = 1'b0;
    resv_nxt     = resv_r;
    resv_id_nxt  = resv_id_r;
    resv_cnt_nxt = resv_cnt_r;
    // reservation age; expiry frees the bank
    for (int i = 0; i < 8; i++) begin
      if (resv_r[i]) begin
        if (resv_cnt_r[i] == 9'(lbbd_pkg::RESV_LIMIT_CYC - 1)) begin
          resv_nxt[i] = 1'b0;
          at_set      = at_set || ctrl_r[lbbd_pkg::CT_AT_EN];
        end else begin
          resv_cnt_nxt[i] = resv_cnt_r[i] + 9'h001;
        end
      end
    end
    // descending scan leaves the lowest matching bank selected
    for (int i = 7; i >= 0; i--) begin
      if (bank_hit(base_r[i], mask_r[i], tr_addr_i)) begin
        hit = 1'b1;
        sel = 3'(i);
      end
    end
    b    = base_r[sel];
    same = resv_id_r[sel] == tr_master_i;
    unique case (ts_r)
      lbbd_pkg::TS_IDLE: begin
        if (tr_valid_i && !term_r && !nom_r) begin // an answered request is not decoded twice
          if (!hit) begin
            nom_nxt = 1'b1;
          end else if (tr_write_i && b[lbbd_pkg::WP_BIT]) begin
            term_nxt = 1'b1;
            wp_set   = ctrl_r[lbbd_pkg::CT_WP_EN];
            berr_nxt = ctrl_r[lbbd_pkg::CT_IRQ_EN];
          end else if (!resv_r[sel] || same) begin
            // another master's reservation holds the request off
            acc_nxt       = 1'b1;
            ts_nxt        = lbbd_pkg::TS_OWN;
            own_bank_nxt  = sel;
            cs_b_nxt      = ~(8'h01 << sel);
            mc_nxt        = b[lbbd_pkg::MC_LSB +: 3];
            pw_nxt        = b[lbbd_pkg::PW_LSB +: 2];
            pm_nxt        = b[lbbd_pkg::PM_LSB +: 2];
            unique case (b[lbbd_pkg::XM_LSB +: 2])
              lbbd_pkg::XM_RAW: begin
                if (tr_write_i) begin
                  resv_nxt[sel]     = 1'b1;
                  resv_id_nxt[sel]  = tr_master_i;
                  resv_cnt_nxt[sel] = 9'h000;
                end else if (resv_r[sel]) begin
                  resv_nxt[sel] = 1'b0;
                end
              end
              lbbd_pkg::XM_WAR: begin
                if (!tr_write_i) begin
                  resv_nxt[sel]     = 1'b1;
                  resv_id_nxt[sel]  = tr_master_i;
                  resv_cnt_nxt[sel] = 9'h000;
                end else if (resv_r[sel]) begin
                  resv_nxt[sel] = 1'b0;
                end
              end
              default: ;
            endcase
            // completing access beats a same-cycle expiry
            if (resv_r[sel] && !resv_nxt[sel] && resv_cnt_r[sel] == 9'(lbbd_pkg::RESV_LIMIT_CYC - 1)) begin
              at_set = 1'b0;
            end
          end
        end
      end
      lbbd_pkg::TS_OWN: begin
        if (tr_end_i) begin
          ts_nxt   = lbbd_pkg::TS_IDLE;
          cs_b_nxt = 8'hFF;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ts_r       <= lbbd_pkg::TS_IDLE;
      own_bank_r <= 3'h0;
      cs_b_r     <= 8'hFF;
      mc_r       <= lbbd_pkg::MC_GENERAL;
      pw_r       <= lbbd_pkg::PW_UNDEF;
      pm_r       <= lbbd_pkg::PM_GEN_ONLY;
      acc_r      <= 1'b0;
      term_r     <= 1'b0;
      nom_r      <= 1'b0;
      berr_r     <= 1'b0;
      resv_r     <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        resv_id_r[i]  <= '0;
        resv_cnt_r[i] <= 9'h000;
      end
    end else if (clk_en_i) begin
      ts_r       <= ts_nxt;
      own_bank_r <= own_bank_nxt;
      cs_b_r     <= cs_b_nxt;
      mc_r       <= mc_nxt;
      pw_r       <= pw_nxt;
      pm_r       <= pm_nxt;
      acc_r      <= acc_nxt;
      term_r     <= term_nxt;
      nom_r      <= nom_nxt;
      berr_r     <= berr_nxt;
      resv_r     <= resv_nxt;
      resv_id_r  <= resv_id_nxt;
      resv_cnt_r <= resv_cnt_nxt;
    end
  end

  assign avs_readdata_o      = rdata_r;
  assign avs_waitrequest_o   = wait_r;
  assign tr_accept_o         = acc_r;
  assign tr_term_o           = term_r;
  assign tr_nomatch_o        = nom_r;
  assign bus_err_o           = berr_r;
  assign chip_select_out_b_o = cs_b_r;
  assign machine_choice_o    = mc_r;
  assign port_width_o        = pw_r;
  assign parity_mode_o       = pm_r;
endmodule // lbbd_bank_decode
`default_nettype wire

/* verif/lbbd_bank_decode_asserts.sv */
// lbbd_bank_decode_asserts: port-level checks for the bank decoder
// assumes: bound to lbbd_bank_decode; clk_en_i held high by the bench
`timescale 1ns/100ps
`default_nettype none
module lbbd_bank_decode_asserts (
  // clock, reset
  input wire logic       core_clk_i,
  input wire logic       rst_b_i,
  // register bus
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  // transactions
  input wire logic       tr_valid_i,
  input wire logic       tr_write_i,
  input wire logic       tr_end_i,
  input wire logic       tr_accept_o,
  input wire logic       tr_term_o,
  input wire logic       tr_nomatch_o,
  input wire logic       bus_err_o,
  input wire logic [7:0] chip_select_out_b_o,
  input wire logic [2:0] machine_choice_o,
  input wire logic [1:0] port_width_o,
  input wire logic [1:0] parity_mode_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----
  // properties
  // ----
  property p_wr_ans; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  property p_wr_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  property p_one_cs; $onehot0(~chip_select_out_b_o); endproperty
  property p_term; tr_term_o |-> (&chip_select_out_b_o) && $past(tr_valid_i && tr_write_i); endproperty
  property p_err; bus_err_o |-> tr_term_o; endproperty
  property p_acc; tr_accept_o |-> $onehot(~chip_select_out_b_o) && $past(tr_valid_i); endproperty
  property p_nom; tr_nomatch_o |-> &chip_select_out_b_o; endproperty
  // ownership must not wander mid-transaction
  property p_hold;
    !(&chip_select_out_b_o) && !tr_end_i
      |=> $stable({chip_select_out_b_o, machine_choice_o, port_width_o, parity_mode_o});
  endproperty
  property p_end; !(&chip_select_out_b_o) && tr_end_i |=> &chip_select_out_b_o; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("register request not answered next cycle");
  a_wr_one: assert property (p_wr_one) else $error("waitrequest low for more than one cycle");
  a_one_cs: assert property (p_one_cs) else $error("more than one chip select active");
  a_term: assert property (p_term) else $error("termination without write or with chip select");
  a_err: assert property (p_err) else $error("bus error without termination");
  a_acc: assert property (p_acc) else $error("accept without a single chip select");
  a_nom: assert property (p_nom) else $error("chip select on unmatched access");
  a_hold: assert property (p_hold) else $error("owned outputs changed before the end");
  a_end: assert property (p_end) else $error("chip select held after the end");
  c_acc: cover property (tr_accept_o);
  c_term: cover property (tr_term_o);
  c_nom: cover property (tr_nomatch_o);
endmodule // lbbd_bank_decode_asserts
bind lbbd_bank_decode lbbd_bank_decode_asserts lbbd_bank_decode_asserts_inst (.core_clk_i, .rst_b_i,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o, .tr_valid_i, .tr_write_i, .tr_end_i, .tr_accept_o,
  .tr_term_o, .tr_nomatch_o, .bus_err_o, .chip_select_out_b_o, .machine_choice_o, .port_width_o,
  .parity_mode_o);
`default_nettype wire

/* verif/lbbd_mem_model.sv */
// lbbd_mem_model: memory on the local bus, ends each owned transaction
// assumes: same clock as the decoder; dly_i sets prompt or slow replies
`timescale 1ns/100ps
`default_nettype none
module lbbd_mem_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] chip_select_out_b_i,
  input  wire logic [3:0] dly_i,
  output logic            tr_end_o
);
  logic [3:0] cnt_r;
  logic       done_r;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 4'h0;
      done_r <= 1'h0;
      tr_end_o <= 1'h0;
    end else begin
      tr_end_o <= 1'h0;
      if (&chip_select_out_b_i) begin
        cnt_r <= 4'h0;
        done_r <= 1'h0;
      end else if (!done_r) begin
        // one end pulse per selection, so no spurious second end
        if (cnt_r == dly_i) begin
          tr_end_o <= 1'h1;
          done_r <= 1'h1;
        end
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule // lbbd_mem_model
`default_nettype wire

/* verif/tb.sv */
// tb: self-checking bench for the bank decoder
// assumes: lbbd_mem_model ends every owned transaction
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
  logic        core_clk_i = 1'h0;
  logic        rst_b_i = 1'h0;
  logic        clk_en_i = 1'h1;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'h0;
  logic        avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [1:0]  boot_port_width_i = lbbd_pkg::PW_16;
  logic        tr_valid_i = 1'h0;
  logic [31:0] tr_addr_i = 32'h0000_0000;
  logic        tr_write_i = 1'h0;
  logic [3:0]  tr_master_i = 4'h0;
  logic [3:0]  mdly = 4'h0;
  logic        tr_end_i, avs_waitrequest_o, tr_accept_o, tr_term_o, tr_nomatch_o, bus_err_o, err_q;
  logic [31:0] avs_readdata_o, q;
  logic [7:0]  chip_select_out_b_o, cs_q;
  logic [2:0]  machine_choice_o, mc_q;
  logic [1:0]  port_width_o, parity_mode_o, pw_q, pm_q, c;
  int          fails = 0;
  int          num_checks = 0;
  int          tcyc;
  lbbd_pkg::lbbd_machine_t mcs [5] = '{lbbd_pkg::MC_GENERAL, lbbd_pkg::MC_SDRAM, lbbd_pkg::MC_USER_A,
                                       lbbd_pkg::MC_USER_B, lbbd_pkg::MC_USER_C};
  localparam logic [31:0] ADDR_HI = 32'h8000_0000;
  always #4 core_clk_i = ~core_clk_i;
  lbbd_bank_decode #(.ID_W(4)) lbbd_bank_decode_inst (.core_clk_i, .rst_b_i, .clk_en_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .boot_port_width_i, .tr_valid_i, .tr_addr_i, .tr_write_i, .tr_master_i, .tr_end_i, .tr_accept_o,
    .tr_term_o, .tr_nomatch_o, .bus_err_o, .chip_select_out_b_o, .machine_choice_o, .port_width_o,
    .parity_mode_o);
  lbbd_mem_model lbbd_mem_model_inst (.core_clk_i, .rst_b_i, .chip_select_out_b_i(chip_select_out_b_o),
    .dly_i(mdly), .tr_end_o(tr_end_i));
  // ----
  // bus and transaction drivers
  // ----
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    // no local limit: only the watchdog ends a hung request
    do begin
      @(posedge core_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
    @(posedge core_clk_i);
  endtask
  task automatic tx(input logic w, input logic [31:0] a, input logic [3:0] m, input int lim);
    int n;
    n = 0;
    c = 2'h0;
    tr_valid_i <= 1'h1;
    tr_write_i <= w;
    tr_addr_i <= a;
    tr_master_i <= m;
    do begin
      @(posedge core_clk_i);
      n++;
      c = (tr_accept_o === 1'b1) ? 2'h1 : (tr_term_o === 1'b1) ? 2'h2 : (tr_nomatch_o === 1'b1) ? 2'h3 : 2'h0;
    end while (c == 2'h0 && n < lim);
    tcyc = n;
    {cs_q, mc_q, pw_q, pm_q, err_q} = {chip_select_out_b_o, machine_choice_o, port_width_o, parity_mode_o, bus_err_o};
    tr_valid_i <= 1'h0;
    while (chip_select_out_b_o !== 8'hFF) begin
      @(posedge core_clk_i);
    end
    @(posedge core_clk_i);
  endtask
  function automatic logic [31:0] bv(logic [1:0] w, logic [1:0] p, logic l, logic [2:0] m, logic [1:0] x);
    return {17'h1_0000, 2'h0, w, p, l, m, 1'h0, x, 1'h0, 1'h1};
  endfunction
  // ----
  // scenarios
  // ----
  task automatic s_reset;
    bus(0, 8'h00, 0); `CHK(q, lbbd_pkg::BASE0_RST | {19'h0_0000, lbbd_pkg::PW_16, 11'h000})
    bus(0, 8'h04, 0); `CHK(q, lbbd_pkg::BASEN_RST)
    bus(0, 8'h20, 0); `CHK(q[16:0], lbbd_pkg::MASK_RST)
    bus(0, 8'h60, 0); `CHK(q, 32'h0000_0000)
    bus(1, 8'h1C, 32'hFFFF_FFFE); bus(0, 8'h1C, 0); `CHK(q, lbbd_pkg::BASE_WMASK & 32'hFFFF_FFFE)
    bus(1, 8'h1C, 0);
    tx(0, 32'h0000_0100, 4'h1, 8); `CHK({c, cs_q, pw_q}, {2'h1, 8'hFE, lbbd_pkg::PW_16})
    tx(0, 32'h0000_8000, 4'h1, 8); `CHK(c, 2'h3)
  endtask
  task automatic s_decode;
    logic [1:0] w, p;
    for (int i = 0; i < 5; i++) begin
      w = 2'(3 - i % 3); // rmw parity only ever paired with 32-bit width
      p = 2'(2 - i % 3);
      bus(1, 8'h08, bv(w, p, 0, mcs[i], lbbd_pkg::XM_NONE));
      tx(0, ADDR_HI, 4'h0, 8); `CHK({c, cs_q, mc_q}, {2'h1, 8'hFB, mcs[i]})
      `CHK({pw_q, pm_q}, {w, p})
    end
    bus(1, 8'h28, 32'h0001_FFFE);
    tx(0, ADDR_HI | 32'h0000_8000, 4'h0, 8); `CHK({c, cs_q}, {2'h1, 8'hFB})
    bus(1, 8'h0C, bv(2'h3, 2'h0, 0, 3'h0, 2'h0));
    tx(0, ADDR_HI, 4'h0, 8); `CHK(cs_q, 8'hFB)
    bus(1, 8'h08, 0);
    tx(0, ADDR_HI, 4'h0, 8); `CHK(cs_q, 8'hF7)
    bus(1, 8'h0C, 0);
  endtask
  task automatic s_wp;
    bus(1, 8'h40, 32'h0000_0007);
    bus(1, 8'h08, bv(lbbd_pkg::PW_32, lbbd_pkg::PM_CHECK, 1, 3'h0, lbbd_pkg::XM_NONE));
    tx(1, ADDR_HI, 4'h0, 8); `CHK({c, err_q, cs_q}, {2'h2, 1'h1, 8'hFF})
    bus(0, 8'h44, 0); `CHK(q[1:0], 2'h1)
    bus(1, 8'h44, 32'h0000_0001); bus(0, 8'h44, 0); `CHK(q[1:0], 2'h0)
    tx(0, ADDR_HI, 4'h0, 8); `CHK(c, 2'h1)
  endtask
  task automatic s_exclusive_reservation_mode;
    mdly <= 4'h7;
    for (int k = 0; k < 2; k++) begin
      bus(1, 8'h08, bv(2'h3, 2'h1, 0, 3'h3, k ? lbbd_pkg::XM_RAW : lbbd_pkg::XM_NONE));
      tx(1, ADDR_HI, 4'h1, 8); `CHK(c, 2'h1)
      tx(0, ADDR_HI, 4'h2, 12); `CHK(c, k ? 2'h0 : 2'h1)
    end
    tx(0, ADDR_HI, 4'h1, 8); `CHK(c, 2'h1)
    tx(0, ADDR_HI, 4'h2, 8); `CHK(c, 2'h1)
    bus(1, 8'h08, bv(2'h3, 2'h1, 0, 3'h3, lbbd_pkg::XM_WAR));
    tx(0, ADDR_HI, 4'h1, 8);
    tx(1, ADDR_HI, 4'h1, 8); `CHK(c, 2'h1)
    tx(1, ADDR_HI, 4'h2, 8); `CHK(c, 2'h1)
    tx(0, ADDR_HI, 4'h1, 8);
    tx(1, ADDR_HI, 4'h2, 400); `CHK({c, 1'(tcyc > 200 && tcyc < 270)}, {2'h1, 1'h1})
    bus(0, 8'h44, 0); `CHK(q[1:0], 2'h2)
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_i);
    fails++;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'h1;
    repeat (8) @(posedge core_clk_i);
    s_reset;
    s_decode;
    s_wp;
    s_exclusive_reservation_mode;
    end_sim;
  end
endmodule // tb
`default_nettype wire
